// ---- src/tmw_pkg.sv ----
// Overview of operation
// - Mode field alone sets counting sequence
// - Non-PWM action: set, clear or toggle
// - Mode 0 counts up, wraps 0xFFFF
// - Normal overflow flag when count becomes zero
// - Overflow flag only set by hardware
// - Normal mode counter writable any time
// - CLEAR_ON_MATCH_MODE clears at compare A or capture
// - CLEAR_ON_MATCH_MODE raises top-defining flag at top
// - CLEAR_ON_MATCH_MODE top unbuffered, low write wraps first
// - CLEAR_ON_MATCH_MODE action 1 toggles output A
// - CLEAR_ON_MATCH_MODE overflow flag at MAX to zero
// - Prescaler 1, 8, 64, 256, 1024
// - Fast PWM tops, clear after top
// - PWM action 2/3 match and bottom
// - PWM overflow and top flag at top
// - Fixed top masks compare writes
// - Capture top unbuffered in fast PWM
// - PWM compare buffered, loaded at top
// - Compare zero spike, top constant
// - PWM toggle only in mode 15
// - Pin shows output only if direction set
// - Counter write blocks next match
// - Compare flag cleared by writing one
package tmw_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_CMPA = 5'h08;
    localparam logic [4:0] OFS_CMPB = 5'h0c;
    localparam logic [4:0] OFS_CAPTOP = 5'h10;
    localparam logic [4:0] OFS_FLAGS = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTA_LSB = 4;
    localparam int CTRL_ACTB_LSB = 6;
    localparam int CTRL_PRESC_LSB = 8;
    localparam int CTRL_DIR_LSB = 11;
    // Flag bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    localparam int FLG_CAP = 3;
    // Waveform modes kept by this block
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_A = 4'h4;
    localparam logic [3:0] MODE_PWM8 = 4'h5;
    localparam logic [3:0] MODE_PWM9 = 4'h6;
    localparam logic [3:0] MODE_PWM10 = 4'h7;
    localparam logic [3:0] MODE_CTC_CAP = 4'hc;
    localparam logic [3:0] MODE_PWM_CAP = 4'he;
    localparam logic [3:0] MODE_PWM_A = 4'hf;
    // Compare output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // Counter extremes and fixed tops
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    // Prescaler masks, divide factor minus one
    localparam logic [9:0] PS_MASK_1 = 10'h000;
    localparam logic [9:0] PS_MASK_8 = 10'h007;
    localparam logic [9:0] PS_MASK_64 = 10'h03f;
    localparam logic [9:0] PS_MASK_256 = 10'h0ff;
    localparam logic [9:0] PS_MASK_1024 = 10'h3ff;
    // Values after reset
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage : tmw_pkg

// ---- src/tmw_timer.sv ----
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tmw_timer
    import tmw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic compare_a_pin,
    output logic compare_a_pin_oe_n,
    output logic compare_b_pin,
    output logic compare_b_pin_oe_n
);
    // Whole block state in one record
    typedef struct packed {
        logic [15:0] cnt;          // Counter value
        logic [9:0] presc;         // Prescaler count
        logic block;               // Match blocked for one tick
        logic [3:0] mode;          // Waveform mode select
        logic [1:0] act_a;         // Compare A output action
        logic [1:0] act_b;         // Compare B output action
        logic [2:0] psel;          // Prescaler select, 0 stops
        logic [1:0] dir;           // Pin direction bits
        logic [15:0] ocra;         // Active compare A
        logic [15:0] ocra_buf;     // Buffered compare A
        logic [15:0] ocrb;         // Active compare B
        logic [15:0] ocrb_buf;     // Buffered compare B
        logic [15:0] icr;          // Capture top value
        logic [3:0] flags;         // Sticky event flags
        logic [1:0] oc;            // Internal compare output state
        logic [1:0] pin;           // Pin data
        logic [1:0] pin_oe_n;      // Pin enables, low drives
        logic wait_q;              // Waitrequest
        logic [31:0] rdata;        // Read data
    } tmw_state_type;

    tmw_state_type st_q;
    tmw_state_type st_d;

    // Bus handshake and timer decode terms
    logic wr_go;    // Write takes effect this edge when clk_en is high
    logic tick;     // Timer clock enable
    logic pwm;      // Fast PWM mode active
    logic clear_on_match_mode;      // Clear-on-match mode active
    logic [15:0] top;
    logic at_top;   // Counter sits on top, not blocked
    logic [1:0] match;
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic [15:0] wmask;
    logic [31:0] rd_v;

    assign wr_go = avs_write && !st_q.wait_q;

    // Merge enabled byte lanes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // Mode decode, prescaler tick and top select
    always_comb begin
        pwm = (st_q.mode == MODE_PWM8) || (st_q.mode == MODE_PWM9) ||
              (st_q.mode == MODE_PWM10) || (st_q.mode == MODE_PWM_CAP) ||
              (st_q.mode == MODE_PWM_A);
        clear_on_match_mode = (st_q.mode == MODE_CTC_A) || (st_q.mode == MODE_CTC_CAP);

        // Divide choice; the free prescaler keeps phase across changes
        case (st_q.psel)
            3'h1: tick = clk_en;
            3'h2: tick = clk_en && ((st_q.presc & PS_MASK_8) == PS_MASK_8);
            3'h3: tick = clk_en && ((st_q.presc & PS_MASK_64) == PS_MASK_64);
            3'h4: tick = clk_en &&
                         ((st_q.presc & PS_MASK_256) == PS_MASK_256);
            3'h5: tick = clk_en && (st_q.presc == PS_MASK_1024);
            default: tick = 1'b0;
        endcase

        // Top of the count per mode
        case (st_q.mode)
            MODE_CTC_A: top = st_q.ocra;
            MODE_PWM_A: top = st_q.ocra;
            MODE_CTC_CAP: top = st_q.icr;
            MODE_PWM_CAP: top = st_q.icr;
            MODE_PWM8: top = TOP_8BIT;
            MODE_PWM9: top = TOP_9BIT;
            MODE_PWM10: top = TOP_10BIT;
            default: top = CNT_MAX;
        endcase

        // Unbuffered tops below count are missed, count runs to MAX
        at_top = (clear_on_match_mode || pwm) && (st_q.cnt == top) && !st_q.block;
        match[0] = (st_q.cnt == st_q.ocra) && !st_q.block;
        match[1] = (st_q.cnt == st_q.ocrb) && !st_q.block;

        // Bits kept by compare writes under a fixed top
        case (st_q.mode)
            MODE_PWM8: wmask = TOP_8BIT;
            MODE_PWM9: wmask = TOP_9BIT;
            MODE_PWM10: wmask = TOP_10BIT;
            default: wmask = CNT_MAX;
        endcase
    end

    // Read mux, unmapped offsets read zero
    always_comb begin
        rd_v = RST_RDATA;
        if (avs_address == OFS_CTRL) begin
            rd_v[CTRL_MODE_LSB +: 4] = st_q.mode;
            rd_v[CTRL_ACTA_LSB +: 2] = st_q.act_a;
            rd_v[CTRL_ACTB_LSB +: 2] = st_q.act_b;
            rd_v[CTRL_PRESC_LSB +: 3] = st_q.psel;
            rd_v[CTRL_DIR_LSB +: 2] = st_q.dir;
        end else if (avs_address == OFS_COUNT) begin
            rd_v[15:0] = st_q.cnt;
        end else if (avs_address == OFS_CMPA) begin
            rd_v[15:0] = pwm ? st_q.ocra_buf : st_q.ocra;
        end else if (avs_address == OFS_CMPB) begin
            rd_v[15:0] = pwm ? st_q.ocrb_buf : st_q.ocrb;
        end else if (avs_address == OFS_CAPTOP) begin
            rd_v[15:0] = st_q.icr;
        end else if (avs_address == OFS_FLAGS) begin
            rd_v[3:0] = st_q.flags;
        end else if (avs_address == OFS_STATUS) begin
            rd_v[1:0] = st_q.oc;
        end
    end

    // Next state of the whole block
    always_comb begin
        st_d = st_q;
        set_v = 4'h0;
        clr_v = 4'h0;
        if (clk_en) begin
            // One wait cycle, then the answer stands for one cycle
            st_d.wait_q = 1'b1;
            if ((avs_read || avs_write) && st_q.wait_q) begin
                st_d.wait_q = 1'b0;
                st_d.rdata = rd_v;
            end

            // Prescaler runs even while stopped
            st_d.presc = st_q.presc + 10'h001;

            if (tick) begin
                // A counter write blocks one timer clock
                st_d.block = 1'b0;
                if (at_top) begin
                    st_d.cnt = CNT_BOTTOM;
                end else begin
                    st_d.cnt = st_q.cnt + 16'h0001;
                end

                // Overflow on wrap or, in fast PWM, at top
                if (pwm) begin
                    set_v[FLG_OVF] = at_top;
                end else begin
                    set_v[FLG_OVF] = (st_q.cnt == CNT_MAX);
                end
                set_v[FLG_CMPA] = match[0];
                set_v[FLG_CMPB] = match[1];
                set_v[FLG_CAP] = at_top && ((st_q.mode == MODE_CTC_CAP) ||
                                 (st_q.mode == MODE_PWM_CAP));

                // Double buffer reloads at top only
                if (pwm && at_top) begin
                    st_d.ocra = st_q.ocra_buf;
                    st_d.ocrb = st_q.ocrb_buf;
                end

                // Output waveform, driven by actions only
                if (!pwm) begin
                    // Non-PWM match actions
                    if (match[0]) begin
                        case (st_q.act_a)
                            ACT_TOGGLE: st_d.oc[0] = !st_q.oc[0];
                            ACT_CLEAR: st_d.oc[0] = 1'b0;
                            ACT_SET: st_d.oc[0] = 1'b1;
                            default: st_d.oc[0] = st_q.oc[0];
                        endcase
                    end

                    if (match[1]) begin
                        case (st_q.act_b)
                            ACT_TOGGLE: st_d.oc[1] = !st_q.oc[1];
                            ACT_CLEAR: st_d.oc[1] = 1'b0;
                            ACT_SET: st_d.oc[1] = 1'b1;
                            default: st_d.oc[1] = st_q.oc[1];
                        endcase
                    end
                end else begin
                    // Bottom action wins so compare at top holds level
                    if (at_top && st_q.act_a[1]) begin
                        st_d.oc[0] = !st_q.act_a[0];
                    end else if (match[0] && st_q.act_a[1]) begin
                        st_d.oc[0] = st_q.act_a[0];
                    end else if (match[0] && st_q.act_a == ACT_TOGGLE &&
                                 st_q.mode == MODE_PWM_A) begin
                        st_d.oc[0] = !st_q.oc[0];
                    end

                    if (at_top && st_q.act_b[1]) begin
                        st_d.oc[1] = !st_q.act_b[0];
                    end else if (match[1] && st_q.act_b[1]) begin
                        st_d.oc[1] = st_q.act_b[0];
                    end
                end
            end

            // Register writes, after the tick so a counter write wins
            if (wr_go) begin
                if (avs_address == OFS_CTRL) begin
                    if (avs_byteenable[0]) begin
                        st_d.mode = avs_writedata[CTRL_MODE_LSB +: 4];
                        st_d.act_a = avs_writedata[CTRL_ACTA_LSB +: 2];
                        st_d.act_b = avs_writedata[CTRL_ACTB_LSB +: 2];
                    end
                    if (avs_byteenable[1]) begin
                        st_d.psel = avs_writedata[CTRL_PRESC_LSB +: 3];
                        st_d.dir = avs_writedata[CTRL_DIR_LSB +: 2];
                    end
                end else if (avs_address == OFS_COUNT) begin
                    // Any time, blocks a match even while stopped
                    st_d.cnt = merge16(st_q.cnt, avs_writedata,
                                       avs_byteenable);
                    st_d.block = 1'b1;
                end else if (avs_address == OFS_CMPA) begin
                    st_d.ocra_buf = merge16(st_q.ocra_buf, avs_writedata,
                                            avs_byteenable) & wmask;
                    if (!pwm) begin
                        st_d.ocra = merge16(st_q.ocra, avs_writedata,
                                            avs_byteenable) & wmask;
                    end
                end else if (avs_address == OFS_CMPB) begin
                    st_d.ocrb_buf = merge16(st_q.ocrb_buf, avs_writedata,
                                            avs_byteenable) & wmask;
                    if (!pwm) begin
                        st_d.ocrb = merge16(st_q.ocrb, avs_writedata,
                                            avs_byteenable) & wmask;
                    end
                end else if (avs_address == OFS_CAPTOP) begin
                    st_d.icr = merge16(st_q.icr, avs_writedata,
                                       avs_byteenable);
                end else if (avs_address == OFS_FLAGS) begin
                    if (avs_byteenable[0]) begin
                        clr_v = avs_writedata[3:0];
                    end
                end
            end

            // Set beats clear when both land together
            st_d.flags = (st_q.flags & ~clr_v) | set_v;

            // Pins follow the internal state only as outputs with a compare action set
            st_d.pin[0] = st_d.dir[0] && (st_d.act_a != ACT_NONE) &&
                          st_d.oc[0];
            st_d.pin[1] = st_d.dir[1] && (st_d.act_b != ACT_NONE) &&
                          st_d.oc[1];
            st_d.pin_oe_n = ~st_d.dir;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.pin_oe_n <= 2'b11;
            st_q.wait_q <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.wait_q;
    assign compare_a_pin = st_q.pin[0];
    assign compare_a_pin_oe_n = st_q.pin_oe_n[0];
    assign compare_b_pin = st_q.pin[1];
    assign compare_b_pin_oe_n = st_q.pin_oe_n[1];

    // Checks, sampled on the timer's own clock
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic cnt_wr;   // Counter write at this edge
    logic flg_wr;   // Flag register write at this edge
    assign cnt_wr = wr_go && clk_en && (avs_address == OFS_COUNT);
    assign flg_wr = wr_go && clk_en && (avs_address == OFS_FLAGS);

    // Counting
    a_normal_wrap: assert property (tick && st_q.mode == MODE_NORMAL &&
        st_q.cnt == CNT_MAX && !cnt_wr |=> st_q.cnt == CNT_BOTTOM)
        else $error("normal mode did not wrap to zero");

    // Flags
    a_normal_ovf: assert property (tick && st_q.mode == MODE_NORMAL &&
        st_q.cnt == CNT_MAX && !flg_wr |=> st_q.flags[FLG_OVF])
        else $error("overflow flag missing at wrap");

    a_ovf_sticky: assert property (st_q.flags[FLG_OVF] &&
        !(flg_wr && avs_writedata[FLG_OVF]) |=> st_q.flags[FLG_OVF])
        else $error("overflow flag dropped without a clear");

    // Clear on match
    a_ctc_clear: assert property (tick && st_q.mode == MODE_CTC_A &&
        match[0] && !cnt_wr && !flg_wr
        |=> st_q.cnt == CNT_BOTTOM && st_q.flags[FLG_CMPA])
        else $error("clear on match failed");

    a_ctc_toggle: assert property (tick && clear_on_match_mode && match[0] &&
        st_q.act_a == ACT_TOGGLE && !wr_go |=> st_q.oc[0] != $past(st_q.oc[0]))
        else $error("compare output A did not toggle");

    // Fast PWM
    a_pwm_fixed_top: assert property (tick && st_q.mode == MODE_PWM9 &&
        st_q.cnt == TOP_9BIT && !st_q.block && !cnt_wr && !flg_wr
        |=> st_q.cnt == CNT_BOTTOM && st_q.flags[FLG_OVF])
        else $error("fixed top not honoured");

    a_buffer_load: assert property (tick && pwm && at_top &&
        !wr_go |=> st_q.ocra == $past(st_q.ocra_buf))
        else $error("compare A buffer not loaded at top");

    a_mask_fixed: assert property (wr_go && clk_en &&
        avs_address == OFS_CMPA && st_q.mode == MODE_PWM8
        |=> st_q.ocra_buf[15:8] == 8'h00)
        else $error("compare write not masked to fixed top");

    // Blocking, pins and bus
    a_block_match: assert property (tick && st_q.block &&
        !clr_v[FLG_CMPA] && !st_q.flags[FLG_CMPA] && !flg_wr
        |=> !st_q.flags[FLG_CMPA])
        else $error("match not blocked after counter write");

    a_pin_hidden: assert property (!st_q.dir[0]
        |-> !compare_a_pin && compare_a_pin_oe_n)
        else $error("compare output A leaked to pin");

    a_bus_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("bus answer late");

    c_ctc_toggle: cover property (tick && clear_on_match_mode && match[0] &&
        st_q.act_a == ACT_TOGGLE);

    c_pwm_top: cover property (tick && pwm && at_top);

    c_normal_wrap: cover property (tick && st_q.mode == MODE_NORMAL &&
        st_q.cnt == CNT_MAX);

    c_cap_top: cover property (tick && at_top && st_q.mode == MODE_CTC_CAP);
endmodule : tmw_timer
`default_nettype wire

// ---- verification/tmw_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Board side of the two compare pins, weak pull-down on each net
module tmw_pin_model (
    input wire logic pin_a,
    input wire logic oe_a_n,
    input wire logic pin_b,
    input wire logic oe_b_n,
    output logic [1:0] level
);
    // A released pin falls to the pull-down, never keeps old data
    assign level = {oe_b_n ? 1'b0 : pin_b, oe_a_n ? 1'b0 : pin_a};
endmodule : tmw_pin_model
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tmw_pkg::*;
    logic ref_clk, rst_n, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, exp_rd, rdv, pin_exp;
    logic [3:0] avs_byteenable, m_fl, st, md, m_md;
    logic pa, pa_oe_n, pb, pb_oe_n, m_blk, m_pw, hit, ma, mb;
    logic [1:0] level, m_oc;
    // Reference copies of the timer registers
    logic [15:0] m_cnt, m_ca, m_cb, m_ba, m_bb, m_cap, m_ctl, m_tp, m_mk;
    logic [15:0] tp, a, b, j, cfg;
    logic [31:0] pin_seen;
    int fail_count = 0;
    int tests_run = 0;
    int rs;
    int dv [4] = '{8, 64, 256, 1024};
    logic [3:0] pm [5] = '{MODE_PWM8, MODE_PWM9, MODE_PWM10, MODE_PWM_CAP,
        MODE_PWM_A};
    assign pin_seen = {28'h0, ~pb_oe_n, ~pa_oe_n, level};
    tmw_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .compare_a_pin(pa),
        .compare_a_pin_oe_n(pa_oe_n), .compare_b_pin(pb),
        .compare_b_pin_oe_n(pb_oe_n));
    tmw_pin_model pins (.pin_a(pa), .oe_a_n(pa_oe_n), .pin_b(pb),
        .oe_b_n(pb_oe_n), .level(level));
    // 125 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] top_of(input logic [3:0] m,
        input logic [15:0] ca, input logic [15:0] cp);
        case (m)
            MODE_CTC_A, MODE_PWM_A: top_of = ca;
            MODE_CTC_CAP, MODE_PWM_CAP: top_of = cp;
            MODE_PWM8: top_of = TOP_8BIT;
            MODE_PWM9: top_of = TOP_9BIT;
            MODE_PWM10: top_of = TOP_10BIT;
            default: top_of = CNT_MAX;
        endcase
    endfunction : top_of
    // Next internal output state; bottom wins over match in fast PWM
    function automatic logic oc_nx(input logic o, input logic [1:0] ac,
        input logic mt, input logic bt, input logic pw, input logic tg);
        if (!pw)
            oc_nx = (!mt || ac == ACT_NONE) ? o
                : (ac == ACT_TOGGLE) ? !o : (ac == ACT_SET);
        else if (ac[1])
            oc_nx = bt ? !ac[0] : mt ? ac[0] : o;
        else
            oc_nx = (ac == ACT_TOGGLE && tg && mt) ? !o : o;
    endfunction : oc_nx
    function automatic logic [31:0] rd(input logic [4:0] ad);
        case (ad)
            OFS_CTRL: rd = {16'h0, m_ctl};
            OFS_COUNT: rd = {16'h0, m_cnt};
            OFS_CMPA: rd = {16'h0, m_ba};
            OFS_CMPB: rd = {16'h0, m_bb};
            OFS_CAPTOP: rd = {16'h0, m_cap};
            OFS_FLAGS: rd = {28'h0, m_fl};
            OFS_STATUS: rd = {30'h0, m_oc};
            default: rd = 32'h0;
        endcase
    endfunction : rd
    // Compare value: bottom, top, or just under top
    function automatic logic [15:0] pick(input logic [15:0] t);
        case ($urandom_range(3))
            0: pick = CNT_BOTTOM;
            1: pick = t;
            default: pick = t - 16'($urandom_range(15));
        endcase
    endfunction : pick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    // Reference model, stepped on the design's enabled clock edges
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {m_cnt, m_ca, m_cb, m_ba, m_bb, m_cap, m_ctl} = '0;
            {m_fl, m_oc, m_blk, exp_rd, pin_exp} = '0;
        end else if (clk_en) begin
            check(pin_seen, pin_exp, "pins");
            if (avs_read && avs_waitrequest) exp_rd = rd(avs_address);
            m_md = m_ctl[3:0];
            m_pw = m_md inside {MODE_PWM8, MODE_PWM9, MODE_PWM10,
                MODE_PWM_CAP, MODE_PWM_A};
            m_tp = top_of(m_md, m_ca, m_cap);
            m_mk = m_md inside {MODE_PWM8, MODE_PWM9, MODE_PWM10} ? m_tp
                : CNT_MAX;
            st = 4'h0;
            // Only the undivided rate is followed here
            if (m_ctl[10:8] == 3'h1) begin
                hit = m_cnt == m_tp && !m_blk;
                ma = m_cnt == m_ca && !m_blk;
                mb = m_cnt == m_cb && !m_blk;
                st[FLG_OVF] = m_pw ? hit : m_cnt == CNT_MAX;
                st[FLG_CMPA] = ma;
                st[FLG_CMPB] = mb;
                st[FLG_CAP] = hit && m_md inside {MODE_CTC_CAP, MODE_PWM_CAP};
                m_oc[0] = oc_nx(m_oc[0], m_ctl[5:4], ma, hit && m_pw, m_pw,
                    m_md == MODE_PWM_A);
                m_oc[1] = oc_nx(m_oc[1], m_ctl[7:6], mb, hit && m_pw, m_pw,
                    1'b0);
                m_cnt = hit ? CNT_BOTTOM : m_cnt + 16'h1;
                if (hit && m_pw) begin
                    m_ca = m_ba;
                    m_cb = m_bb;
                end
                m_blk = 1'b0;
            end
            if (avs_write && !avs_waitrequest) begin
                case (avs_address)
                    OFS_CTRL: m_ctl = avs_writedata[15:0] & 16'h1fff;
                    OFS_COUNT: begin
                        m_cnt = avs_writedata[15:0];
                        m_blk = 1'b1;
                    end
                    OFS_CMPA: m_ba = avs_writedata[15:0] & m_mk;
                    OFS_CMPB: m_bb = avs_writedata[15:0] & m_mk;
                    OFS_CAPTOP: m_cap = avs_writedata[15:0];
                    OFS_FLAGS: m_fl = m_fl & ~avs_writedata[3:0];
                    default: ;
                endcase
                if (!m_pw) begin
                    m_ca = m_ba;
                    m_cb = m_bb;
                end
            end
            m_fl = m_fl | st;
            pin_exp = {28'h0, m_ctl[12:11],
                m_oc & m_ctl[12:11] & {|m_ctl[7:6], |m_ctl[5:4]}};
        end
    end
    // One transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] ad,
        input logic [15:0] d, input logic chk);
        int n;
        n = 0;
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            complete_run();
        end
        rdv = avs_readdata;
        if (!wr && chk) check(rdv, exp_rd, "readdata");
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    // Set up stopped, run, rewrite compare A mid-run, read everything
    task automatic run(input logic [15:0] cf, c, ca, cb, cp, a2, jk,
        input int cyc);
        bus(1'b1, OFS_CTRL, 16'h0000, 1'b1);
        bus(1'b1, OFS_CAPTOP, cp, 1'b1);
        bus(1'b1, OFS_CMPA, ca, 1'b1);
        bus(1'b1, OFS_CMPB, cb, 1'b1);
        bus(1'b1, OFS_COUNT, c, 1'b1);
        bus(1'b1, OFS_FLAGS, 16'h000f, 1'b1);
        bus(1'b1, OFS_CTRL, cf & 16'hf8ff, 1'b1);
        bus(1'b1, OFS_CMPA, ca | jk, 1'b1);
        bus(1'b1, OFS_CMPB, cb | jk, 1'b1);
        bus(1'b1, OFS_CTRL, cf, 1'b1);
        repeat (cyc) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        bus(1'b1, OFS_CMPA, a2, 1'b1);
        repeat (cyc) @(posedge ref_clk);
        for (int k = 0; k < 28; k += 4) bus(1'b0, 5'(k), 16'h0, 1'b1);
    endtask : run
    initial begin
        rs = $urandom(32'h6036fb00);
        {rst_n, avs_read, avs_write} = 3'b000;
        clk_en = 1'b1;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 32; k += 4) bus(1'b0, 5'(k), 16'h0, 1'b1);
        run(16'h1970, 16'hfff0, 16'hfff6, 16'h0004, 16'h0000, 16'h0009,
            16'h0000, 20);
        run(16'h0914, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 20);
        run(16'h19a4, 16'hfff0, 16'h0005, 16'h0003, 16'h0000, 16'h0006,
            16'h0000, 25);
        run(16'h19dc, 16'hfff8, 16'h0002, 16'h0003, 16'h0004, 16'h0002,
            16'h0000, 20);
        run(16'h0914, 16'h0030, 16'h0030, 16'h0030, 16'h0000, 16'h0030,
            16'h0000, 10);
        run(16'h19ee, 16'hfff8, 16'h0008, 16'h0004, 16'h0010, 16'h0008,
            16'h0000, 20);
        // Fast PWM, every mode, random actions and pin directions
        for (int i = 0; i < 15; i++) begin
            md = pm[i % 5];
            a = 16'h0020 + 16'($urandom_range(31));
            tp = top_of(md, a, a);
            a = md == MODE_PWM_A ? tp : pick(tp);
            b = pick(tp);
            j = md inside {MODE_PWM_CAP, MODE_PWM_A} ? 16'h0
                : ~tp & 16'($urandom);
            cfg = {3'h0, 2'($urandom), 3'h1, 4'($urandom), md};
            run(cfg, tp - 16'h0014, a, b, tp,
                md == MODE_PWM_A ? tp + 16'h0004 : pick(tp) | j, j,
                30);
        end
        // Divided tick rates last, since the model follows only divide-by-1
        for (int s = 2; s < 6; s++) begin
            bus(1'b1, OFS_CTRL, 16'h0000, 1'b1);
            bus(1'b1, OFS_COUNT, 16'h0000, 1'b1);
            bus(1'b1, OFS_CTRL, 16'(s << 8), 1'b1);
            repeat (4 * dv[s - 2]) @(posedge ref_clk);
            bus(1'b0, OFS_COUNT, 16'h0, 1'b0);
            check({31'h0, rdv[15:0] inside {16'h4, 16'h5}}, 32'h1, "ticks");
        end
        complete_run();
    end
endmodule : testbench
`default_nettype wire
